/* File: core/cuo_regs.svh */
// Register indices, field positions, reset values, opcodes and cycle counts.
`ifndef CUO_REGS_SVH
`define CUO_REGS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define CUO_IDX_CTRL 8'h00
`define CUO_IDX_INSTR0 8'h01
`define CUO_IDX_INSTR1 8'h02
`define CUO_IDX_INSTR2 8'h03
`define CUO_IDX_PC_LO 8'h04
`define CUO_IDX_PC_HI 8'h05
`define CUO_IDX_STK 8'h06
`define CUO_IDX_MODE 8'h07
`define CUO_IDX_MEM_ADDR 8'h08
`define CUO_IDX_MEM_DATA 8'h09
`define CUO_IDX_IRQ_PEND 8'h0a
`define CUO_IDX_FLAGS 8'hd5

// ---------------------------------------------------------------
// Register-space addresses and field positions
// ---------------------------------------------------------------
`define CUO_FLAGS_ADDR 8'hd5
`define CUO_WREG_BASE 4'hc
`define CUO_FLAG_C 7
`define CUO_FLAG_Z 6
`define CUO_FLAG_S 5
`define CUO_FLAG_V 4
`define CUO_MODE_IE 3
`define CUO_CTRL_GO 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CUO_FLAGS_RST 8'h00
`define CUO_MODE_RST 8'h00
`define CUO_STK_RST 8'h00
`define CUO_PC_RST 16'h0000

// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define CUO_OP_DECR_R 8'h00
`define CUO_OP_DECR_IND 8'h01
`define CUO_OP_INV_R 8'h60
`define CUO_OP_INV_IND 8'h61
`define CUO_OP_ZERO_R 8'hb0
`define CUO_OP_ZERO_IND 8'hb1
`define CUO_OP_CMP_RR 8'ha2
`define CUO_OP_CMP_RIND 8'ha3
`define CUO_OP_CMP_R_R 8'ha4
`define CUO_OP_CMP_R_IND 8'ha5
`define CUO_OP_CMP_R_IMM 8'ha6
`define CUO_OP_CALL_DIR 8'hf6
`define CUO_OP_CALL_PAIR 8'hf4
`define CUO_OP_CINV 8'hef
`define CUO_OP_IDIS 8'h8f

// ---------------------------------------------------------------
// Cycle counts and instruction lengths
// ---------------------------------------------------------------
`define CUO_CYC_CALL_DIR 4'he
`define CUO_CYC_CALL_PAIR 4'hc
`define CUO_CYC_SHORT 4'h4
`define CUO_CYC_LONG 4'h6
`define CUO_LEN_1 16'h0001
`define CUO_LEN_2 16'h0002
`define CUO_LEN_3 16'h0003

`endif

/* File: core/cuo_pkg.sv */
// Types shared by the call and unary-operation core.
package cuo_pkg;
  typedef logic [7:0] cuo_byte_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_PUSH_HI, ST_WAIT} cuo_state_e;
endpackage : cuo_pkg

/* File: core/cuo_alu.sv */
// Result and flag computation for decrement, complement, clear, compare.
`timescale 1ns/1ps
`include "cuo_regs.svh"
module cuo_alu (
  input wire cuo_pkg::cuo_byte_t opcode,
  input wire cuo_pkg::cuo_byte_t dst,
  input wire cuo_pkg::cuo_byte_t src,
  input wire cuo_pkg::cuo_byte_t flags_in,
  output cuo_pkg::cuo_byte_t result,
  output cuo_pkg::cuo_byte_t flags_out,
  output logic wr_en
);
  import cuo_pkg::*;

  logic [8:0] diff;

  // Computes the write-back value and the new flags for one opcode.
  always_comb begin
    diff = {1'b0, dst} - {1'b0, src};
    result = dst;
    flags_out = flags_in;
    wr_en = 1'b0;
    case (opcode)
      `CUO_OP_DECR_R, `CUO_OP_DECR_IND: begin
        result = dst - 8'h01;
        wr_en = 1'b1;
        flags_out[`CUO_FLAG_Z] = (result == 8'h00);
        flags_out[`CUO_FLAG_S] = result[7];
        flags_out[`CUO_FLAG_V] = (dst == 8'h80);
      end
      `CUO_OP_INV_R, `CUO_OP_INV_IND: begin
        result = ~dst;
        wr_en = 1'b1;
        flags_out[`CUO_FLAG_Z] = (result == 8'h00);
        flags_out[`CUO_FLAG_S] = result[7];
        flags_out[`CUO_FLAG_V] = 1'b0;
      end
      `CUO_OP_ZERO_R, `CUO_OP_ZERO_IND: begin
        result = 8'h00;
        wr_en = 1'b1;
      end
      `CUO_OP_CMP_RR, `CUO_OP_CMP_RIND, `CUO_OP_CMP_R_R, `CUO_OP_CMP_R_IND,
      `CUO_OP_CMP_R_IMM: begin
        flags_out[`CUO_FLAG_C] = diff[8];
        flags_out[`CUO_FLAG_Z] = (diff[7:0] == 8'h00);
        flags_out[`CUO_FLAG_S] = diff[7];
        flags_out[`CUO_FLAG_V] = (dst[7] != src[7]) &&
                                 (diff[7] == src[7]);
      end
      `CUO_OP_CINV: begin
        flags_out[`CUO_FLAG_C] = ~flags_in[`CUO_FLAG_C];
      end
      default: begin
        result = dst;
      end
    endcase
  end
endmodule : cuo_alu

/* File: core/cuo_core.sv */
// Call, carry-complement and unary-operation core with an APB slave.
`timescale 1ns/1ps
`include "cuo_regs.svh"
// Function
// - Call pushes low then high, flags untouched
// - Return address follows the whole call
// - Call loads target; F6 14, F4 12
// - Complement-carry inverts carry only
// - Flags register lives at address D5
// - Clear writes zero, no flag change
// - Complement inverts every destination bit
// - Complement sets Z, S; clears V
// - Compare opcodes A2-A6 with cycle counts
// - Compare sets Z, S, writes nothing
// - Compare carry is borrow; overflow rule
// - Decrement subtracts one, keeps carry
// - Decrement overflow only 80 to 7F
// - Interrupt disable clears mode bit 3
// - Disabled requests still pend, not serviced
// - Re-enabling services left pending requests
module cuo_core #(
  parameter int IRQ_N = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [IRQ_N-1:0] irq_req,
  output logic irq_taken,
  output cuo_pkg::cuo_byte_t irq_id
);
  import cuo_pkg::*;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_call(input cuo_byte_t op);
    is_call = (op == `CUO_OP_CALL_DIR) || (op == `CUO_OP_CALL_PAIR);
  endfunction : is_call

  function automatic logic is_cmp(input cuo_byte_t op);
    is_cmp = (op >= `CUO_OP_CMP_RR) && (op <= `CUO_OP_CMP_R_IMM);
  endfunction : is_cmp

  function automatic logic [15:0] op_len(input cuo_byte_t op);
    case (op)
      `CUO_OP_CALL_DIR, `CUO_OP_CMP_R_R, `CUO_OP_CMP_R_IND,
      `CUO_OP_CMP_R_IMM: op_len = `CUO_LEN_3;
      `CUO_OP_CINV, `CUO_OP_IDIS: op_len = `CUO_LEN_1;
      default: op_len = `CUO_LEN_2;
    endcase
  endfunction : op_len

  function automatic logic [3:0] op_cycles(input cuo_byte_t op);
    case (op)
      `CUO_OP_CALL_DIR: op_cycles = `CUO_CYC_CALL_DIR;
      `CUO_OP_CALL_PAIR: op_cycles = `CUO_CYC_CALL_PAIR;
      `CUO_OP_CMP_RIND, `CUO_OP_CMP_R_R, `CUO_OP_CMP_R_IND,
      `CUO_OP_CMP_R_IMM: op_cycles = `CUO_CYC_LONG;
      default: op_cycles = `CUO_CYC_SHORT;
    endcase
  endfunction : op_cycles

  function automatic logic is_legal(input cuo_byte_t op);
    case (op)
      `CUO_OP_DECR_R, `CUO_OP_DECR_IND, `CUO_OP_INV_R, `CUO_OP_INV_IND,
      `CUO_OP_ZERO_R, `CUO_OP_ZERO_IND, `CUO_OP_CALL_DIR, `CUO_OP_CALL_PAIR,
      `CUO_OP_CINV, `CUO_OP_IDIS: is_legal = 1'b1;
      default: is_legal = is_cmp(op);
    endcase
  endfunction : is_legal

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cuo_state_e st_q;
  cuo_byte_t mem_q [0:255];
  cuo_byte_t flags_q, mode_q, stk_q, mem_addr_q;
  cuo_byte_t op_q, b1_q, b2_q;
  logic [15:0] pc_q, tgt_q, ret_q;
  logic [3:0] cnt_q;
  logic illegal_q;
  logic [IRQ_N-1:0] pend_q;
  logic busy, exec, pushing;

  assign busy = (st_q != ST_IDLE);
  assign exec = (st_q == ST_EXEC);
  assign pushing = (st_q == ST_PUSH_HI);

  // Register-space read: address D5 is the flags register itself.
  function automatic cuo_byte_t rd(input cuo_byte_t a);
    rd = (a == `CUO_FLAGS_ADDR) ? flags_q : mem_q[a];
  endfunction : rd

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [7:0] idx;
  logic mapped, wr_fire, rd_take;
  logic [31:0] rdata;

  assign idx = paddr[9:2];
  assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                  ((idx <= `CUO_IDX_IRQ_PEND) || (idx == `CUO_IDX_FLAGS));
  assign wr_fire = psel && penable && pwrite && pready && mapped;
  assign rd_take = psel && penable && !pready;

  // Selects the readback word; upper bits read as zero.
  always_comb begin
    rdata = 32'h0000_0000;
    case (idx)
      `CUO_IDX_CTRL: rdata[1:0] = {illegal_q, busy};
      `CUO_IDX_INSTR0: rdata[7:0] = op_q;
      `CUO_IDX_INSTR1: rdata[7:0] = b1_q;
      `CUO_IDX_INSTR2: rdata[7:0] = b2_q;
      `CUO_IDX_PC_LO: rdata[7:0] = pc_q[7:0];
      `CUO_IDX_PC_HI: rdata[7:0] = pc_q[15:8];
      `CUO_IDX_STK: rdata[7:0] = stk_q;
      `CUO_IDX_MODE: rdata[7:0] = mode_q;
      `CUO_IDX_MEM_ADDR: rdata[7:0] = mem_addr_q;
      `CUO_IDX_MEM_DATA: rdata[7:0] = rd(mem_addr_q);
      `CUO_IDX_IRQ_PEND: rdata[IRQ_N-1:0] = pend_q;
      `CUO_IDX_FLAGS: rdata[7:0] = flags_q;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= rd_take;
      pslverr <= rd_take && !mapped;
      if (rd_take) begin
        prdata <= mapped ? rdata : 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Operand fetch and ALU
  // ---------------------------------------------------------------
  cuo_byte_t dst_addr, dst_val, src_val, alu_res, alu_flags;
  logic alu_we, flag_dst;
  logic [7:0] wd, ws;

  assign wd = {`CUO_WREG_BASE, b1_q[7:4]};
  assign ws = {`CUO_WREG_BASE, b1_q[3:0]};

  // Resolves destination address and source value per addressing mode.
  always_comb begin
    dst_addr = b1_q;
    src_val = 8'h00;
    case (op_q)
      `CUO_OP_DECR_IND, `CUO_OP_INV_IND,
      `CUO_OP_ZERO_IND: dst_addr = rd(b1_q);
      `CUO_OP_CMP_RR: begin
        dst_addr = wd;
        src_val = rd(ws);
      end
      `CUO_OP_CMP_RIND: begin
        dst_addr = wd;
        src_val = rd(rd(ws));
      end
      `CUO_OP_CMP_R_R: begin
        dst_addr = b2_q;
        src_val = rd(b1_q);
      end
      `CUO_OP_CMP_R_IND: begin
        dst_addr = b2_q;
        src_val = rd(rd(b1_q));
      end
      `CUO_OP_CMP_R_IMM: src_val = b2_q;
      default: dst_addr = b1_q;
    endcase
  end

  assign dst_val = rd(dst_addr);
  assign flag_dst = alu_we && (dst_addr == `CUO_FLAGS_ADDR);

  cuo_alu u_alu (
    .opcode(op_q),
    .dst(dst_val),
    .src(src_val),
    .flags_in(flags_q),
    .result(alu_res),
    .flags_out(alu_flags),
    .wr_en(alu_we)
  );

  // ---------------------------------------------------------------
  // Data memory write port
  // ---------------------------------------------------------------
  logic mem_we;
  cuo_byte_t mem_wa, mem_wd;

  // Stack pushes and results win; APB writes only reach memory when idle.
  always_comb begin
    mem_we = 1'b0;
    mem_wa = dst_addr;
    mem_wd = alu_res;
    if (exec && is_call(op_q)) begin
      mem_we = 1'b1;
      mem_wa = stk_q - 8'h01;
      mem_wd = ret_q[7:0];
    end else if (pushing) begin
      mem_we = 1'b1;
      mem_wa = stk_q - 8'h01;
      mem_wd = ret_q[15:8];
    end else if (exec) begin
      mem_we = alu_we && !flag_dst;
    end else if (!busy && wr_fire && idx == `CUO_IDX_MEM_DATA) begin
      mem_we = 1'b1;
      mem_wa = mem_addr_q;
      mem_wd = pwdata[7:0];
    end
  end

  // Memory array; the flags address is shadowed by the flags register.
  always_ff @(posedge pclk) begin
    if (ce && mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic go;
  assign go = !busy && wr_fire && idx == `CUO_IDX_CTRL &&
              pwdata[`CUO_CTRL_GO];

  // Steps one instruction and pads it to its documented cycle count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      illegal_q <= 1'b0;
    end else if (ce) begin
      if (busy) begin
        cnt_q <= cnt_q - 4'h1;
      end
      case (st_q)
        ST_IDLE: begin
          if (go) begin
            st_q <= ST_EXEC;
            cnt_q <= op_cycles(op_q) - 4'h1;
            illegal_q <= 1'b0;
          end
        end
        ST_EXEC: begin
          illegal_q <= !is_legal(op_q);
          st_q <= is_call(op_q) ? ST_PUSH_HI : ST_WAIT;
        end
        ST_PUSH_HI: st_q <= ST_WAIT;
        ST_WAIT: begin
          if (cnt_q == 4'h0) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Instruction bytes and memory pointer, writable only while idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      mem_addr_q <= 8'h00;
    end else if (ce && wr_fire && !busy) begin
      case (idx)
        `CUO_IDX_INSTR0: op_q <= pwdata[7:0];
        `CUO_IDX_INSTR1: b1_q <= pwdata[7:0];
        `CUO_IDX_INSTR2: b2_q <= pwdata[7:0];
        `CUO_IDX_MEM_ADDR: mem_addr_q <= pwdata[7:0];
        default: mem_addr_q <= mem_addr_q;
      endcase
    end
  end

  // Return address and call target, captured when leaving idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_q <= `CUO_PC_RST;
      tgt_q <= `CUO_PC_RST;
    end else if (ce && go) begin
      ret_q <= pc_q + op_len(op_q);
      tgt_q <= (op_q == `CUO_OP_CALL_DIR) ? {b1_q, b2_q} :
               {rd(b1_q), rd({b1_q[7:1], 1'b1})};
    end
  end

  // Program counter: target after a call, next instruction after any other legal opcode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= `CUO_PC_RST;
    end else if (ce) begin
      if (pushing) begin
        pc_q <= tgt_q;
      end else if (exec && !is_call(op_q) && is_legal(op_q)) begin
        pc_q <= ret_q;
      end else if (!busy && wr_fire && idx == `CUO_IDX_PC_LO) begin
        pc_q[7:0] <= pwdata[7:0];
      end else if (!busy && wr_fire && idx == `CUO_IDX_PC_HI) begin
        pc_q[15:8] <= pwdata[7:0];
      end
    end
  end

  // Stack pointer drops once per pushed byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stk_q <= `CUO_STK_RST;
    end else if (ce) begin
      if ((exec && is_call(op_q)) || pushing) begin
        stk_q <= stk_q - 8'h01;
      end else if (!busy && wr_fire && idx == `CUO_IDX_STK) begin
        stk_q <= pwdata[7:0];
      end
    end
  end

  // Flags: an explicit write to address D5 beats the computed flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `CUO_FLAGS_RST;
    end else if (ce) begin
      if (exec && flag_dst) begin
        flags_q <= alu_res;
      end else if (exec) begin
        flags_q <= alu_flags;
      end else if (!busy && wr_fire && (idx == `CUO_IDX_FLAGS ||
               (idx == `CUO_IDX_MEM_DATA &&
                mem_addr_q == `CUO_FLAGS_ADDR))) begin
        flags_q <= pwdata[7:0];
      end
    end
  end

  // System mode: interrupt disable clears the global enable bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `CUO_MODE_RST;
    end else if (ce) begin
      if (exec && op_q == `CUO_OP_IDIS) begin
        mode_q[`CUO_MODE_IE] <= 1'b0;
      end else if (!busy && wr_fire && idx == `CUO_IDX_MODE) begin
        mode_q <= pwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt pending and service
  // ---------------------------------------------------------------
  logic [IRQ_N-1:0] pick, drop;
  logic [7:0] pick_id;
  logic svc;

  // Lowest-numbered pending request is chosen for service.
  always_comb begin
    pick = '0;
    pick_id = 8'h00;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        pick = '0;
        pick[i] = 1'b1;
        pick_id = 8'(i);
      end
    end
  end

  assign svc = mode_q[`CUO_MODE_IE] && (pend_q != '0) && !busy;
  assign drop = (svc ? pick : '0) |
               ((wr_fire && idx == `CUO_IDX_IRQ_PEND) ?
                pwdata[IRQ_N-1:0] : '0);

  // Requests pend whenever ce is high; a new request beats a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
      irq_taken <= 1'b0;
      irq_id <= 8'h00;
    end else if (ce) begin
      pend_q <= (pend_q & ~drop) | irq_req;
      irq_taken <= svc;
      if (svc) begin
        irq_id <= pick_id;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_PUSH_STK: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && exec && is_call(op_q)) |=>
      (stk_q == $past(stk_q) - 8'h01) && (flags_q == $past(flags_q)))
    else $error("call push did not drop the stack pointer by one");

  AST_RET_ADDR: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && go && op_q == `CUO_OP_CALL_PAIR) |=>
      ret_q == $past(pc_q) + 16'h0002)
    else $error("two-byte call saved a wrong return address");

  AST_CALL_PC: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && pushing) |=> (pc_q == $past(tgt_q)) && (st_q == ST_WAIT))
    else $error("call did not load the target after pushing");

  AST_CINV: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && exec && op_q == `CUO_OP_CINV) |=>
      flags_q == ($past(flags_q) ^ 8'h80))
    else $error("carry complement touched the wrong flags");

  AST_ZERO_FLAGS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && exec && !flag_dst &&
     (op_q == `CUO_OP_ZERO_R || op_q == `CUO_OP_ZERO_IND)) |=>
      $stable(flags_q))
    else $error("clear changed the flags");

  AST_INV_FLAGS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && exec && !flag_dst && op_q == `CUO_OP_INV_R) |=>
      !flags_q[`CUO_FLAG_V] &&
      (flags_q[`CUO_FLAG_S] == !$past(dst_val[7])) &&
      (flags_q[`CUO_FLAG_C] == $past(flags_q[`CUO_FLAG_C])))
    else $error("complement flags wrong");

  AST_CMP_NOWRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (exec && is_cmp(op_q)) |-> !mem_we)
    else $error("compare wrote an operand");

  AST_CMP_BORROW: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && exec && is_cmp(op_q)) |=>
      flags_q[`CUO_FLAG_C] == ($past(src_val) > $past(dst_val)))
    else $error("compare borrow flag wrong");

  AST_DECR_V: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && exec && !flag_dst && op_q == `CUO_OP_DECR_R) |=>
      flags_q[`CUO_FLAG_V] == ($past(dst_val) == 8'h80))
    else $error("decrement overflow flag wrong");

  AST_IDIS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && exec && op_q == `CUO_OP_IDIS) |=>
      !mode_q[`CUO_MODE_IE] && $stable(flags_q))
    else $error("interrupt disable left the enable bit set");

  AST_NO_SVC: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && !mode_q[`CUO_MODE_IE]) |=> !irq_taken)
    else $error("interrupt serviced while disabled");

  AST_CALL_LEN: assert property (
    @(posedge pclk) disable iff (!presetn || !ce)
    (go && op_q == `CUO_OP_CALL_DIR) |=>
      busy [*7] ##1 busy [*7] ##1 !busy)
    else $error("direct call did not take fourteen cycles");

  AST_PAIR_LEN: assert property (
    @(posedge pclk) disable iff (!presetn || !ce)
    (go && op_q == `CUO_OP_CALL_PAIR) |=>
      busy [*6] ##1 busy [*6] ##1 !busy)
    else $error("pair call did not take twelve cycles");

  AST_CMP_LEN: assert property (
    @(posedge pclk) disable iff (!presetn || !ce)
    (go && is_cmp(op_q) && op_q != `CUO_OP_CMP_RR) |=>
      busy [*6] ##1 !busy)
    else $error("long compare did not take six cycles");

endmodule : cuo_core

/* File: testbench/testbench.sv */
// Self-checking testbench for the call and unary-operation core.
`timescale 1ns/1ps
`include "cuo_regs.svh"
module testbench;
  import cuo_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_taken;
  logic [7:0] irq_req = 8'h00;
  cuo_byte_t irq_id;
  int n_fail = 0;
  int num_checks = 0;
  int n_taken = 0;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] cop [5] = '{8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6};
  logic [7:0] cb1 [5] = '{8'h13, 8'h12, 8'h31, 8'hc2, 8'h30};
  logic [7:0] cb2 [5] = '{8'h00, 8'h00, 8'h30, 8'h30, 8'h03};

  // The 200 MHz clock.
  always #2.5 pclk = ~pclk;

  // Serviced interrupts are counted here.
  always @(posedge pclk) begin
    if (irq_taken === 1'b1) n_taken++;
  end

  cuo_core #(.IRQ_N(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .irq_taken(irq_taken), .irq_id(irq_id)
  );

  // --------------------
  // Bus and check tasks
  // --------------------
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic tmo;
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    test_done;
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) tmo;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rdat, {24'h000000, e});
  endtask : rd

  task automatic mw(input logic [7:0] a, input logic [7:0] d);
    wr(`CUO_IDX_MEM_ADDR, a);
    wr(`CUO_IDX_MEM_DATA, d);
  endtask : mw

  task automatic mr(input logic [7:0] a, input logic [7:0] e);
    wr(`CUO_IDX_MEM_ADDR, a);
    rd(`CUO_IDX_MEM_DATA, e);
  endtask : mr

  // Loads one instruction, starts it and polls until busy drops.
  task automatic ex(input logic [7:0] op, input logic [7:0] b1,
                    input logic [7:0] b2);
    int i;
    wr(`CUO_IDX_INSTR0, op);
    wr(`CUO_IDX_INSTR1, b1);
    wr(`CUO_IDX_INSTR2, b2);
    wr(`CUO_IDX_CTRL, 8'h01);
    for (i = 0; i < 10; i++) begin
      apb(1'b0, `CUO_IDX_CTRL, 8'h00);
      if (rdat[0] === 1'b0) break;
    end
    if (i == 10) tmo;
  endtask : ex

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    int i;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CUO_IDX_FLAGS, `CUO_FLAGS_RST);
    rd(`CUO_IDX_MODE, `CUO_MODE_RST);
    apb(1'b0, 8'h40, 8'h00);
    chk({rdat[30:0], rerr}, 32'h00000001);
    // Carry complement touches only the carry bit.
    wr(`CUO_IDX_FLAGS, 8'h70);
    ex(`CUO_OP_CINV, 8'h00, 8'h00);
    rd(`CUO_IDX_FLAGS, 8'hf0);
    mr(8'hd5, 8'hf0);
    // Clear in both forms, flags kept.
    mw(8'h10, 8'h4f);
    ex(`CUO_OP_ZERO_R, 8'h10, 8'h00);
    mr(8'h10, 8'h00);
    mw(8'h11, 8'h12);
    mw(8'h12, 8'h5e);
    ex(`CUO_OP_ZERO_IND, 8'h11, 8'h00);
    mr(8'h12, 8'h00);
    rd(`CUO_IDX_FLAGS, 8'hf0);
    // Complement with a negative and a zero result.
    mw(8'h07, 8'h07);
    wr(`CUO_IDX_FLAGS, 8'h90);
    ex(`CUO_OP_INV_R, 8'h07, 8'h00);
    mr(8'h07, 8'hf8);
    rd(`CUO_IDX_FLAGS, 8'ha0);
    mw(8'h21, 8'hff);
    mw(8'h20, 8'h21);
    wr(`CUO_IDX_FLAGS, 8'h90);
    ex(`CUO_OP_INV_IND, 8'h20, 8'h00);
    mr(8'h21, 8'h00);
    rd(`CUO_IDX_FLAGS, 8'hc0);
    // Every compare form on 02 minus 03, then overflow and equality.
    mw(8'h30, 8'h02);
    mw(8'h31, 8'h03);
    mw(8'hc1, 8'h02);
    mw(8'hc2, 8'h31);
    mw(8'hc3, 8'h03);
    for (i = 0; i < 5; i++) begin
      wr(`CUO_IDX_FLAGS, 8'h00);
      ex(cop[i], cb1[i], cb2[i]);
      rd(`CUO_IDX_FLAGS, 8'ha0);
    end
    mr(8'h30, 8'h02);
    mr(8'hc1, 8'h02);
    mw(8'h30, 8'h80);
    ex(`CUO_OP_CMP_R_IMM, 8'h30, 8'h01);
    rd(`CUO_IDX_FLAGS, 8'h10);
    mw(8'h30, 8'h05);
    ex(`CUO_OP_CMP_R_IMM, 8'h30, 8'h05);
    rd(`CUO_IDX_FLAGS, 8'h40);
    // Decrement across 80 to 7f, then an ordinary step.
    mw(8'h40, 8'h80);
    wr(`CUO_IDX_FLAGS, 8'h80);
    ex(`CUO_OP_DECR_R, 8'h40, 8'h00);
    mr(8'h40, 8'h7f);
    rd(`CUO_IDX_FLAGS, 8'h90);
    mw(8'h41, 8'h40);
    ex(`CUO_OP_DECR_IND, 8'h41, 8'h00);
    mr(8'h40, 8'h7e);
    rd(`CUO_IDX_FLAGS, 8'h80);
    // Direct and indirect calls from 1a47 with the stack at b2.
    mw(8'hc0, 8'h15);
    mw(8'hc1, 8'h21);
    for (i = 0; i < 2; i++) begin
      wr(`CUO_IDX_STK, 8'hb2);
      wr(`CUO_IDX_PC_LO, 8'h47);
      wr(`CUO_IDX_PC_HI, 8'h1a);
      wr(`CUO_IDX_FLAGS, 8'h50);
      if (i == 0) ex(`CUO_OP_CALL_DIR, 8'h15, 8'h21);
      else ex(`CUO_OP_CALL_PAIR, 8'hc0, 8'h00);
      rd(`CUO_IDX_PC_LO, 8'h21);
      rd(`CUO_IDX_PC_HI, 8'h15);
      rd(`CUO_IDX_STK, 8'hb0);
      mr(8'hb1, (i == 0) ? 8'h4a : 8'h49);
      mr(8'hb0, 8'h1a);
      rd(`CUO_IDX_FLAGS, 8'h50);
    end
    // Disable, let a request pend, then enable again.
    wr(`CUO_IDX_MODE, 8'h08);
    ex(`CUO_OP_IDIS, 8'h00, 8'h00);
    rd(`CUO_IDX_MODE, 8'h00);
    irq_req <= 8'h04;
    repeat (3) @(posedge pclk);
    irq_req <= 8'h00;
    rd(`CUO_IDX_IRQ_PEND, 8'h04);
    chk(n_taken, 32'h0);
    wr(`CUO_IDX_MODE, 8'h08);
    for (i = 0; i < 10; i++) begin
      @(posedge pclk);
      if (n_taken == 1) break;
    end
    chk(n_taken, 32'h1);
    chk({24'h000000, irq_id}, 32'h2);
    rd(`CUO_IDX_IRQ_PEND, 8'h00);
    // A request seen only while the clock enable is low must not pend.
    ce <= 1'b0;
    irq_req <= 8'h01;
    repeat (3) @(posedge pclk);
    irq_req <= 8'h00;
    ce <= 1'b1;
    rd(`CUO_IDX_IRQ_PEND, 8'h00);
    chk(n_taken, 32'h1);
    test_done;
  end
endmodule : testbench
